// ### design/pms_pkg.sv
// Package of constants and types for the power mode sequencer
//****************************************************************
// Summary of operation
// - Software alone requests idle, standby, shutdown, held
// - Idle stops core clocks; any interrupt wakes
// - Standby powers always-on domain, SRAM and sensor
// - Standby exits on pin, counter, sensor event
// - Standby wake resumes execution, keeps retention
// - Standby latches all I/O pins
// - Shutdown powers everything off, I/O latched
// - Shutdown pin change wakes as reset
// - Reset status records pin, reset, power-on cause
// - Shutdown keeps only the I/O latch; flash is off
// - Wake sources allowed per mode table
// - Wake latency 14, 151, 1015 microseconds
// - Standby brownout locks device until reset
// - Software picks fast crystal or RC clock
// - Crystal reference doubled to fast clock
// - Slow RC used when no slow crystal
// - Always-on domain powered except shutdown
//****************************************************************
package pms_pkg;
    // Clock rate of the sequencer in kHz
    localparam int unsigned CLOCK_KHZ        = 20000;
    // Wake latencies in nanoseconds
    localparam int unsigned IDLE_WAKE_NS     = 14000;
    localparam int unsigned STANDBY_WAKE_NS  = 151000;
    localparam int unsigned RESET_WAKE_NS    = 1015000;
    // All times round down, never below one cycle
    localparam int unsigned IDLE_WAKE_CYC    = (IDLE_WAKE_NS * (CLOCK_KHZ / 1000)) / 1000;
    localparam int unsigned STANDBY_WAKE_CYC = (STANDBY_WAKE_NS * (CLOCK_KHZ / 1000)) / 1000;
    localparam int unsigned RESET_WAKE_CYC   = (RESET_WAKE_NS * (CLOCK_KHZ / 1000)) / 1000;
    localparam int unsigned CNT_W            = 16;
    // Register offsets
    localparam logic [3:0] ADDR_MODE_REQ    = 4'h0;
    localparam logic [3:0] ADDR_STATUS      = 4'h1;
    localparam logic [3:0] ADDR_RESET_CAUSE = 4'h2;
    localparam logic [3:0] ADDR_CLK_CFG     = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'h5;
    localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h6;
    localparam logic [3:0] ADDR_WAKE_PINS   = 4'h7;
    // Mode request codes
    localparam logic [2:0] REQ_IDLE     = 3'h1;
    localparam logic [2:0] REQ_STANDBY  = 3'h2;
    localparam logic [2:0] REQ_SHUTDOWN = 3'h3;
    localparam logic [2:0] REQ_HELD     = 3'h4;
    // Reset cause codes
    localparam logic [1:0] CAUSE_POR    = 2'h0;
    localparam logic [1:0] CAUSE_PIN    = 2'h1;
    localparam logic [1:0] CAUSE_WAKEIO = 2'h2;
    // Interrupt event bits
    localparam int unsigned EV_W        = 4;
    localparam int unsigned EV_WAKE     = 0;
    localparam int unsigned EV_SLEEP    = 1;
    localparam int unsigned EV_LOCK     = 2;
    localparam int unsigned EV_REFUSED  = 3;
    // Clock config bits
    localparam int unsigned CFG_FAST_XTAL = 0;
    // Modes, Gray along the listed order, active through boot
    typedef enum logic [2:0] {
        PMS_ACTIVE   = 3'h0,
        PMS_IDLE     = 3'h1,
        PMS_WAKE     = 3'h3,
        PMS_STANDBY  = 3'h2,
        PMS_SHUTDOWN = 3'h6,
        PMS_HELD     = 3'h7,
        PMS_BOOT     = 3'h5
    } pms_state_t;
endpackage

// ### design/pms_sync.sv
// Two-flop synchroniser for a vector of pin inputs
module pms_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import pms_pkg::*;
    typedef struct packed {
        logic [WIDTH-1:0] first;  // Metastable stage, read only by second
        logic [WIDTH-1:0] second; // Safe stage
    } pms_sync_t;
    pms_sync_t st;
    pms_sync_t next_st;
    // Shift chain
    always_comb begin
        next_st.first  = i_async;
        next_st.second = st.first;
    end
    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign o_sync = st.second;
endmodule

// ### design/pms_clock_sel.sv
// Clock source selection for the fast and slow references
module pms_clock_sel (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_fast_xtal_sel,
    input  wire logic i_fast_on,
    input  wire logic i_slow_on,
    input  wire logic i_slow_xtal_present,
    output logic      o_fast_crystal_osc_en,
    output logic      o_fast_rc_osc_en,
    output logic      o_doubler_en,
    output logic      o_slow_crystal_osc_en,
    output logic      o_slow_rc_osc_en
);
    import pms_pkg::*;
    typedef struct packed {
        logic fx;  // Fast crystal enable
        logic frc; // Fast RC enable
        logic dbl; // Doubler enable
        logic sx;  // Slow crystal enable
        logic src; // Slow RC enable
    } pms_clk_t;
    pms_clk_t st;
    pms_clk_t next_st;
    // Enables follow the mode; fast clocks only when the fast domain runs
    always_comb begin
        next_st.fx  = i_fast_on & i_fast_xtal_sel;
        next_st.frc = i_fast_on & ~i_fast_xtal_sel;
        next_st.dbl = i_fast_on & i_fast_xtal_sel;
        next_st.sx  = i_slow_on & i_slow_xtal_present;
        next_st.src = i_slow_on & ~i_slow_xtal_present;
    end
    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign {o_fast_crystal_osc_en, o_fast_rc_osc_en, o_doubler_en, o_slow_crystal_osc_en,
            o_slow_rc_osc_en} = st;
endmodule

// ### design/pms_top.sv
// Power mode sequencer: mode machine, gating, wake routing, registers
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module pms_top #(
    parameter int unsigned GPIO_W        = 8,
    parameter int unsigned STANDBY_CYC   = pms_pkg::STANDBY_WAKE_CYC,
    parameter int unsigned RESET_CYC     = pms_pkg::RESET_WAKE_CYC
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    // Register port
    input  wire logic [3:0]        i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    // Event and pin inputs
    input  wire logic              i_irq_any,
    input  wire logic              i_rtc_event,
    input  wire logic              i_sensor_event,
    input  wire logic              i_ext_wake,
    input  wire logic              i_reset_pin_n,
    input  wire logic              i_brownout,
    input  wire logic              i_recharge,
    input  wire logic              i_slow_xtal_present,
    input  wire logic [GPIO_W-1:0] i_gpio_in,
    // Power and clock gating
    output logic                   o_cpu_clk_en,
    output logic                   o_cpu_rst,
    output logic                   o_flash_on,
    output logic                   o_sram_on,
    output logic                   o_radio_on,
    output logic                   o_periph_on,
    output logic                   o_always_on_domain_on,
    output logic                   o_sensor_on,
    output logic                   o_brownout_detector_en,
    output logic                   o_retain,
    output logic                   o_io_latch,
    output logic                   o_fast_crystal_osc_en,
    output logic                   o_fast_rc_osc_en,
    output logic                   o_doubler_en,
    output logic                   o_slow_crystal_osc_en,
    output logic                   o_slow_rc_osc_en,
    output logic                   o_irq
);
    import pms_pkg::*;

    initial begin
        if (GPIO_W < 1 || GPIO_W > 16) $error("GPIO_W out of range");
        if (RESET_CYC < 1 || RESET_CYC >= (1 << CNT_W)) $error("RESET_CYC out of range");
        if (STANDBY_CYC < 1 || STANDBY_CYC > RESET_CYC) $error("STANDBY_CYC out of range");
    end

    //****************************************************************
    // Pin synchronisers
    //****************************************************************
    localparam int unsigned SW = GPIO_W + 6;
    logic [SW-1:0] raw_pins;
    logic [SW-1:0] syn_pins;
    assign raw_pins = {i_gpio_in, i_rtc_event, i_sensor_event, i_ext_wake,
                       i_reset_pin_n, i_brownout, i_recharge};
    pms_sync #(
        .WIDTH (SW)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (raw_pins),
        .o_sync  (syn_pins)
    );
    logic [GPIO_W-1:0] gpio_s;
    logic              rtc_s;
    logic              sens_s;
    logic              ext_s;
    logic              rpin_n_s;
    logic              bo_s;
    logic              rech_s;
    assign {gpio_s, rtc_s, sens_s, ext_s, rpin_n_s, bo_s, rech_s} = syn_pins;

    //****************************************************************
    // State
    //****************************************************************
    typedef struct packed {
        pms_state_t        mode;       // Current mode
        logic [CNT_W-1:0]  cnt;        // Wake latency counter
        logic              cold;       // Wake in progress is a full reset
        logic [1:0]        cause;      // Last reset cause
        logic              bo_seen;    // Brownout caught during standby
        logic              locked;     // Brownout lockup after wake
        logic              fast_xtal;  // Fast clock source choice
        logic [GPIO_W-1:0] wake_en;    // Shutdown wake pin mask
        logic [GPIO_W-1:0] io_snap;    // Pin levels at shutdown entry
        logic [EV_W-1:0]   irq_st;     // Sticky events
        logic [EV_W-1:0]   irq_en;     // Event enables
        logic              rpin_prev;  // Reset pin level last cycle
        logic [31:0]       rdata;      // Read data register
    } pms_top_t;
    pms_top_t st;
    pms_top_t next_st;

    // Mode whose wake sequence is a full reset
    function automatic logic is_cold(input pms_state_t m);
        return (m == PMS_SHUTDOWN) || (m == PMS_HELD);
    endfunction

    //****************************************************************
    // Next-state logic
    //****************************************************************
    always_comb begin
        logic [EV_W-1:0] ev;
        logic            rpin_fall;
        logic            pin_wake;
        ev        = '0;
        next_st   = st;
        rpin_fall = st.rpin_prev & ~rpin_n_s;
        // Change on an enabled wake pin against the latched level
        pin_wake  = |((gpio_s ^ st.io_snap) & st.wake_en);
        next_st.rpin_prev = rpin_n_s;
        next_st.rdata     = '0;

        // Reset pin wakes from every mode, including held
        if (rpin_fall) begin
            next_st.mode   = PMS_BOOT;
            next_st.cold   = 1'b1;
            next_st.cnt    = CNT_W'(RESET_CYC);
            next_st.cause  = CAUSE_PIN;
            next_st.locked = 1'b0;
        end else begin
            unique case (st.mode)
                PMS_ACTIVE: begin
                    // Only software starts a low-power mode
                    if (i_wr && i_addr == ADDR_MODE_REQ && !st.locked) begin
                        unique case (i_wdata[2:0])
                            REQ_IDLE: begin
                                next_st.mode = PMS_IDLE;
                                ev[EV_SLEEP] = 1'b1;
                            end
                            REQ_STANDBY: begin
                                next_st.mode    = PMS_STANDBY;
                                next_st.bo_seen = 1'b0;
                                ev[EV_SLEEP]    = 1'b1;
                            end
                            REQ_SHUTDOWN: begin
                                next_st.mode    = PMS_SHUTDOWN;
                                next_st.io_snap = gpio_s;
                            end
                            REQ_HELD: begin
                                next_st.mode = PMS_HELD;
                            end
                            default: ev[EV_REFUSED] = 1'b1;
                        endcase
                    end
                end
                PMS_IDLE: begin
                    // Any interrupt or counter wake returns to active
                    if (i_irq_any || rtc_s || ext_s || sens_s) begin
                        next_st.mode = PMS_WAKE;
                        next_st.cold = 1'b0;
                        next_st.cnt  = CNT_W'(IDLE_WAKE_CYC);
                    end
                end
                PMS_STANDBY: begin
                    // Brownout sampled only during recharge
                    if (rech_s && bo_s) begin
                        next_st.bo_seen = 1'b1;
                    end
                    if (ext_s || rtc_s || sens_s) begin
                        next_st.mode = PMS_WAKE;
                        next_st.cold = 1'b0;
                        next_st.cnt  = CNT_W'(STANDBY_CYC);
                    end
                end
                PMS_SHUTDOWN: begin
                    if (pin_wake) begin
                        next_st.mode  = PMS_BOOT;
                        next_st.cold  = 1'b1;
                        next_st.cnt   = CNT_W'(RESET_CYC);
                        next_st.cause = CAUSE_WAKEIO;
                    end
                end
                PMS_HELD: begin
                    // Only the reset pin exits, handled above
                    next_st.mode = PMS_HELD;
                end
                PMS_WAKE, PMS_BOOT: begin
                    if (st.cnt <= CNT_W'(1)) begin
                        next_st.mode = PMS_ACTIVE;
                        ev[EV_WAKE]  = 1'b1;
                        if (st.bo_seen) begin
                            next_st.locked = 1'b1;
                            ev[EV_LOCK]    = 1'b1;
                        end
                        next_st.bo_seen = 1'b0;
                    end else begin
                        next_st.cnt = st.cnt - CNT_W'(1);
                    end
                end
                default: next_st.mode = PMS_BOOT;
            endcase
        end

        // Registers wiped by a full reset wake
        if (st.mode == PMS_BOOT) begin
            next_st.fast_xtal = 1'b0;
            next_st.wake_en   = '0;
            next_st.irq_en    = '0;
        end else if (i_wr) begin
            unique case (i_addr)
                ADDR_CLK_CFG:    next_st.fast_xtal = i_wdata[CFG_FAST_XTAL];
                ADDR_IRQ_ENABLE: next_st.irq_en    = i_wdata[EV_W-1:0];
                ADDR_WAKE_PINS:  next_st.wake_en   = i_wdata[GPIO_W-1:0];
                default: ;
            endcase
        end

        // Sticky events: set wins over clear
        if (i_wr && i_addr == ADDR_IRQ_CLEAR) begin
            next_st.irq_st = st.irq_st & ~i_wdata[EV_W-1:0];
        end
        if (st.mode == PMS_BOOT) begin
            next_st.irq_st = '0;
        end
        next_st.irq_st = next_st.irq_st | ev;

        // Read data, valid the cycle after the strobe
        if (i_rd) begin
            unique case (i_addr)
                ADDR_STATUS:      next_st.rdata = {27'h0, st.locked, st.cold, 3'(st.mode)};
                ADDR_RESET_CAUSE: next_st.rdata = {30'h0, st.cause};
                ADDR_CLK_CFG:     next_st.rdata = {31'h0, st.fast_xtal};
                ADDR_IRQ_STATUS:  next_st.rdata = {28'h0, st.irq_st};
                ADDR_IRQ_ENABLE:  next_st.rdata = {28'h0, st.irq_en};
                ADDR_WAKE_PINS:   next_st.rdata = 32'(st.wake_en);
                default:          next_st.rdata = 32'h0;
            endcase
        end
    end

    //****************************************************************
    // State register
    //****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            // Power-on boot; edge detector starts low like the synchroniser,
            // so a reset pin idling high gives no false edge
            st           <= '0;
            st.mode      <= PMS_BOOT;
            st.cold      <= 1'b1;
            st.cnt       <= CNT_W'(RESET_CYC);
            st.cause     <= CAUSE_POR;
            st.rpin_prev <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    //****************************************************************
    // Gating outputs, decoded from the registered mode
    //****************************************************************
    logic act;
    logic fast_dom;
    assign act      = (st.mode == PMS_ACTIVE);
    assign fast_dom = act || (st.mode == PMS_IDLE) || (st.mode == PMS_WAKE);

    // Cause is registered before the processor leaves reset
    assign o_cpu_clk_en           = act && !st.locked;
    assign o_cpu_rst              = (st.mode == PMS_BOOT);
    assign o_flash_on             = fast_dom;
    assign o_radio_on             = fast_dom;
    assign o_periph_on            = fast_dom;
    assign o_sram_on              = !is_cold(st.mode);
    assign o_retain               = (st.mode == PMS_STANDBY) || (st.mode == PMS_WAKE);
    assign o_always_on_domain_on  = (st.mode != PMS_SHUTDOWN);
    assign o_sensor_on            = !is_cold(st.mode);
    assign o_brownout_detector_en = fast_dom || ((st.mode == PMS_STANDBY) && rech_s);
    assign o_io_latch             = (st.mode == PMS_STANDBY) || is_cold(st.mode);
    assign o_irq                  = |(st.irq_st & st.irq_en);
    assign o_rdata                = st.rdata;

    pms_clock_sel u_clk (
        .i_clock               (i_clock),
        .i_rst                 (i_rst),
        .i_fast_xtal_sel       (st.fast_xtal),
        .i_fast_on             (fast_dom),
        .i_slow_on             (o_always_on_domain_on),
        .i_slow_xtal_present   (i_slow_xtal_present),
        .o_fast_crystal_osc_en (o_fast_crystal_osc_en),
        .o_fast_rc_osc_en      (o_fast_rc_osc_en),
        .o_doubler_en          (o_doubler_en),
        .o_slow_crystal_osc_en (o_slow_crystal_osc_en),
        .o_slow_rc_osc_en      (o_slow_rc_osc_en)
    );
endmodule

// ### tb/pms_chk.sv
// Checker of the power mode sequencer outputs
module pms_chk #(
    parameter int unsigned STANDBY_CYC = 4
) (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_rd,
    input wire logic        i_irq_any,
    input wire logic        i_rtc_event,
    input wire logic        i_reset_pin_n,
    input wire logic        i_slow_xtal_present,
    input wire logic [31:0] o_rdata,
    input wire logic        o_cpu_clk_en,
    input wire logic        o_cpu_rst,
    input wire logic        o_flash_on,
    input wire logic        o_sram_on,
    input wire logic        o_radio_on,
    input wire logic        o_periph_on,
    input wire logic        o_always_on_domain_on,
    input wire logic        o_sensor_on,
    input wire logic        o_retain,
    input wire logic        o_io_latch,
    input wire logic        o_fast_crystal_osc_en,
    input wire logic        o_fast_rc_osc_en,
    input wire logic        o_doubler_en,
    input wire logic        o_slow_rc_osc_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slack covers the pin synchroniser and the clock enable stage
    localparam int WAKE_MAX = STANDBY_CYC + 12;
    // Mode decodes from the gating outputs alone
    wire stby = o_retain && o_io_latch;
    wire held = o_io_latch && !o_sram_on && o_always_on_domain_on;
    wire idle = o_flash_on && !o_retain && !o_cpu_clk_en && !o_cpu_rst;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    // Counter event seen for three cycles while asleep
    sequence s_rtc_seen;
        (stby && i_rtc_event) [*3];
    endsequence
    standby_gate_a: assert property (stby |-> !o_flash_on && !o_radio_on && !o_periph_on && o_sram_on)
        else $error("standby gating wrong");
    standby_fast_a: assert property (stby && $past(stby) |-> !o_fast_crystal_osc_en && !o_fast_rc_osc_en)
        else $error("fast clock on in standby");
    shutdown_off_a: assert property (!o_always_on_domain_on |-> o_io_latch && !o_sram_on && !o_sensor_on)
        else $error("shutdown left power on");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data without read");
    boot_hold_a: assert property ($rose(o_cpu_rst) |=> o_cpu_rst [*7])
        else $error("boot cut short");
    held_stay_a: assert property (i_reset_pin_n [*3] ##1 (held && i_reset_pin_n) |=> held)
        else $error("held left without reset pin");
    doubler_pair_a: assert property (o_doubler_en == o_fast_crystal_osc_en)
        else $error("doubler apart from crystal");
    fast_excl_a: assert property (!(o_fast_crystal_osc_en && o_fast_rc_osc_en))
        else $error("two fast sources");
    slow_pick_a: assert property ((o_always_on_domain_on && !i_slow_xtal_present) [*3] |-> o_slow_rc_osc_en)
        else $error("slow rc not used");
    idle_wake_a: assert property (idle && i_irq_any |-> ##[1:290] o_cpu_clk_en)
        else $error("idle did not wake");
    standby_wake_a: assert property (s_rtc_seen |-> ##[1:WAKE_MAX] o_cpu_clk_en)
        else $error("standby did not wake");
endmodule
bind pms_top pms_chk #(.STANDBY_CYC(STANDBY_CYC)) u_pms_chk (.*);

// ### tb/pms_src.sv
// Model of the wake event sources around the sequencer
module pms_src (
    input  wire logic [3:0] i_fire,
    input  wire logic       i_clock,
    output logic            o_irq_any,
    output logic            o_rtc_event,
    output logic            o_sensor_event,
    output logic            o_ext_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sh = 32'h0;   // Eight cycles of history per source
    logic [3:0]  lvl;          // Event levels, low when released
    // Each event is a level held eight cycles, long enough to cross the synchroniser
    always @(posedge i_clock) sh <= {sh[27:0], i_fire};
    always_comb begin
        lvl = 4'h0;
        for (int j = 0; j < 8; j++) lvl |= sh[4*j +: 4];
    end
    assign {o_ext_wake, o_sensor_event, o_rtc_event, o_irq_any} = lvl;
endmodule

// ### tb/tb.sv
// Testbench of the power mode sequencer
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pms_pkg::*;
    logic i_clock = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_reset_pin_n = 1, i_slow_xtal_present = 0;
    logic [3:0] i_addr = 4'h0, fire = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, rdv;
    logic [7:0] i_gpio_in = 8'h5a;
    logic i_irq_any, i_rtc_event, i_sensor_event, i_ext_wake, o_cpu_clk_en, o_cpu_rst, o_flash_on, o_sram_on;
    logic o_radio_on, o_periph_on, o_always_on_domain_on, o_sensor_on, o_brownout_detector_en, o_retain;
    logic o_io_latch, o_fast_crystal_osc_en, o_fast_rc_osc_en, o_doubler_en, o_slow_crystal_osc_en;
    logic o_slow_rc_osc_en, o_irq;
    int failures = 0, n_tests = 0;
    always #25 i_clock = ~i_clock;
    // Brownout inputs are tied quiet: standby is only entered on a good supply
    pms_top #(.STANDBY_CYC(4), .RESET_CYC(8)) u_pms_top (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_irq_any, .i_rtc_event, .i_sensor_event, .i_ext_wake, .i_reset_pin_n, .i_brownout(1'b0),
        .i_recharge(1'b0), .i_slow_xtal_present, .i_gpio_in, .o_cpu_clk_en, .o_cpu_rst, .o_flash_on,
        .o_sram_on, .o_radio_on, .o_periph_on, .o_always_on_domain_on, .o_sensor_on, .o_brownout_detector_en,
        .o_retain, .o_io_latch, .o_fast_crystal_osc_en, .o_fast_rc_osc_en, .o_doubler_en,
        .o_slow_crystal_osc_en, .o_slow_rc_osc_en, .o_irq);
    pms_src u_pms_src (.i_fire(fire), .i_clock, .o_irq_any(i_irq_any), .o_rtc_event(i_rtc_event),
        .o_sensor_event(i_sensor_event), .o_ext_wake(i_ext_wake));
    //****************************************************************
    // Register port tasks
    //****************************************************************
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 rdv = o_rdata;
    endtask
    task automatic chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        rd(a);
        `CHK(nm, e, rdv & m)
    endtask
    // Poll the mode field under a bounded count
    task automatic wait_mode(input logic [2:0] m);
        rd(ADDR_STATUS);
        for (int k = 0; k < 400 && rdv[2:0] !== m; k++) rd(ADDR_STATUS);
        chk(ADDR_STATUS, 32'h7, {29'h0, m}, "mode");
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic pulse(input logic [3:0] f);
        @(posedge i_clock);
        fire <= f;
        @(posedge i_clock);
        fire <= 4'h0;
    endtask
    task automatic give_verdict;
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    //****************************************************************
    // Scenarios
    //****************************************************************
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        wait_mode(3'h0);
        chk(ADDR_RESET_CAUSE, 32'h3, {30'h0, CAUSE_POR}, "cause");
        chk(4'hf, 32'hffffffff, 32'h0, "unmapped");
        wr(ADDR_CLK_CFG, 32'h1);
        settle(3);
        `CHK("xtal", 3'b110, {o_fast_crystal_osc_en, o_doubler_en, o_fast_rc_osc_en})
        wr(ADDR_CLK_CFG, 32'h0);
        settle(3);
        `CHK("rc", 4'b1001, {o_fast_rc_osc_en, o_fast_crystal_osc_en, o_doubler_en, o_slow_rc_osc_en})
        // Unknown code is refused and flagged
        wr(ADDR_MODE_REQ, 32'h5);
        chk(ADDR_IRQ_STATUS, 32'h8, 32'h8, "refused");
        chk(ADDR_STATUS, 32'h7, 32'h0, "mode");
        wr(ADDR_IRQ_ENABLE, 32'h2);
        wr(ADDR_MODE_REQ, {29'h0, REQ_IDLE});
        chk(ADDR_STATUS, 32'h7, 32'h1, "idle");
        `CHK("idle gate", 3'b011, {o_cpu_clk_en, o_flash_on, o_irq})
        wr(ADDR_IRQ_CLEAR, 32'hf);
        settle(2);
        `CHK("irq low", 1'b0, o_irq)
        pulse(4'h1);
        wait_mode(3'h0);
        i_slow_xtal_present <= 1'b1;
        // Standby left by counter, sensor and pin events in turn
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_IRQ_CLEAR, 32'hf);
            wr(ADDR_MODE_REQ, {29'h0, REQ_STANDBY});
            chk(ADDR_STATUS, 32'h7, 32'h2, "standby");
            `CHK("stby pwr", 9'b000011111, {o_flash_on, o_radio_on, o_periph_on, o_brownout_detector_en, o_io_latch,
                o_retain, o_always_on_domain_on, o_sram_on, o_slow_crystal_osc_en})
            if (s == 1) begin
                pulse(4'h1);
                chk(ADDR_STATUS, 32'h7, 32'h2, "irq ignored");
            end
            pulse(4'h1 << s);
            wait_mode(3'h0);
            chk(ADDR_IRQ_STATUS, 32'h1, 32'h1, "resumed");
            chk(ADDR_RESET_CAUSE, 32'h3, {30'h0, CAUSE_POR}, "no reset");
        end
        // Shutdown woken only by an enabled pin, as a reset
        wr(ADDR_WAKE_PINS, 32'h1);
        wr(ADDR_MODE_REQ, {29'h0, REQ_SHUTDOWN});
        i_gpio_in <= 8'h58;
        settle(20);
        `CHK("shutdown", 4'b0001, {o_always_on_domain_on, o_sram_on, o_sensor_on, o_io_latch})
        i_gpio_in <= 8'h59;
        wait_mode(3'h0);
        chk(ADDR_RESET_CAUSE, 32'h3, {30'h0, CAUSE_WAKEIO}, "pin cause");
        chk(ADDR_WAKE_PINS, 32'h1, 32'h0, "pins lost");
        // Held ignores counter and pins, leaves on the reset pin
        wr(ADDR_WAKE_PINS, 32'h1);
        wr(ADDR_MODE_REQ, {29'h0, REQ_HELD});
        pulse(4'h2);
        i_gpio_in <= 8'h58;
        settle(20);
        `CHK("held", 3'b101, {o_always_on_domain_on, o_sram_on, o_io_latch})
        i_reset_pin_n <= 1'b0;
        settle(6);
        i_reset_pin_n <= 1'b1;
        wait_mode(3'h0);
        chk(ADDR_RESET_CAUSE, 32'h3, {30'h0, CAUSE_PIN}, "reset cause");
        give_verdict;
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge i_clock);
        failures++;
        give_verdict;
    end
endmodule
